/* src/gdp_pkg.sv */
// constants and types shared by the general digital io port
package gdp_pkg;
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 8;
    // register offsets
    localparam logic [3:0] ADDR_INPUT = 4'h0;
    localparam logic [3:0] ADDR_DIRECTION = 4'h1;
    localparam logic [3:0] ADDR_DRIVE = 4'h2;
    localparam logic [3:0] ADDR_SPECIAL_FUNC = 4'h3;
    localparam logic [3:0] ADDR_DRIVE_SET = 4'h4;
    localparam logic [3:0] ADDR_DRIVE_CLR = 4'h5;
    localparam logic [3:0] ADDR_DIR_SET = 4'h6;
    localparam logic [3:0] ADDR_DIR_CLR = 4'h7;
    // field position of the global pull-up disable
    localparam int PULLUP_DIS_BIT = 2;
    // reset values
    localparam logic [7:0] RESET_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_DRIVE = 8'h00;
    localparam logic RESET_PULLUP_DIS = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // pin configuration codes {direction,drive}
    typedef enum logic [1:0] {
        GDP_CFG_TRISTATE = 2'b00,
        GDP_CFG_PULLUP = 2'b01,
        GDP_CFG_LOW = 2'b10,
        GDP_CFG_HIGH = 2'b11
    } gdp_cfg_t;
endpackage : gdp_pkg

/* src/gdp_pin_if.sv */
// interface carrying per-pin control from the register file to the pad logic
`timescale 1ns/10ps
interface gdp_pin_if;
    logic [gdp_pkg::PORT_WIDTH-1:0] direction;
    logic [gdp_pkg::PORT_WIDTH-1:0] drive;
    logic pullup_dis;
    logic [gdp_pkg::PORT_WIDTH-1:0] out_level;
    logic [gdp_pkg::PORT_WIDTH-1:0] out_en_n;
    logic [gdp_pkg::PORT_WIDTH-1:0] pullup_en;
    modport ctrl (output direction, output drive, output pullup_dis,
                  input out_level, input out_en_n, input pullup_en);
    modport pad (input direction, input drive, input pullup_dis,
                 output out_level, output out_en_n, output pullup_en);
endinterface : gdp_pin_if

/* src/gdp_pad_ctrl.sv */
// pad drive and pull-up decoding for all pins of a port
`timescale 1ns/10ps
module gdp_pad_ctrl (
    input wire logic rst_active_i,
    gdp_pin_if.pad pin
);
    always_comb begin
        for (int n = 0; n < gdp_pkg::PORT_WIDTH; n++) begin
            // reset forces tri-state even with no clock
            pin.out_en_n[n] = rst_active_i | ~pin.direction[n];
            pin.out_level[n] = pin.drive[n];
            // pull-up only on {dir,drive}=01 with global disable low
            pin.pullup_en[n] = ~rst_active_i & ~pin.pullup_dis &
                ({pin.direction[n], pin.drive[n]} == gdp_pkg::GDP_CFG_PULLUP);
        end
    end
endmodule : gdp_pad_ctrl

/* src/gdp_input_sync.sv */
// latch plus register synchroniser for the port input pins
`timescale 1ns/10ps
module gdp_input_sync (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [gdp_pkg::PORT_WIDTH-1:0] pin_i,
    output logic [gdp_pkg::PORT_WIDTH-1:0] sync_o
);
    logic [gdp_pkg::PORT_WIDTH-1:0] sync_latch;
    logic [gdp_pkg::PORT_WIDTH-1:0] next_sync;
    // transparent while clock high, holds after fall
    always_latch begin
        if (sys_clk_i) begin
            sync_latch <= pin_i;
        end
    end
    always_comb begin
        next_sync = clk_en_i ? sync_latch : sync_o;
    end
    // latch output taken at next rising edge
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_o <= gdp_pkg::READ_ZERO;
        end else begin
            sync_o <= next_sync;
        end
    end
endmodule : gdp_input_sync

/* src/gdp_port.sv */
// general digital io port: registers, pad control and input synchroniser
// Contract
// - each port has a read/write drive register, a read/write direction register and a read-only input register.
// - single pins may be set or cleared in direction or drive without touching other pins.
// - direction one makes the pin an output, zero an input.
// - the pull-up is on only for an input with drive one and global disable low, else the input floats.
// - the global pull-up disable turns off every pull-up whatever the pin settings.
// - an output pin drives its drive bit, regardless of the pull-up disable.
// - during reset all pins are tri-stated, even with no clock.
// - the input bit follows the pin level in any direction through a latch and a register.
// - the latch is open while the clock is high and is sampled at the next rising edge.
// - a written pin level reads back one clock later, so software waits one idle cycle.
// - pins taken by another function leave the others usable as general io.
// - the global pull-up disable sits in bit 2 of the special function register.
`timescale 1ns/10ps
module gdp_port (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [gdp_pkg::ADDR_WIDTH-1:0] addr_i,
    input wire logic [gdp_pkg::DATA_WIDTH-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [gdp_pkg::DATA_WIDTH-1:0] rdata_o,
    input wire logic [gdp_pkg::PORT_WIDTH-1:0] pad_in_i,
    output logic [gdp_pkg::PORT_WIDTH-1:0] pad_out_o,
    output logic [gdp_pkg::PORT_WIDTH-1:0] pad_oe_n_o,
    output logic [gdp_pkg::PORT_WIDTH-1:0] pad_pullup_o
);
    logic rst_meta;
    logic rst_sync;
    logic [gdp_pkg::PORT_WIDTH-1:0] port_direction_reg;
    logic [gdp_pkg::PORT_WIDTH-1:0] port_drive_reg;
    logic global_pullup_disable;
    logic [gdp_pkg::PORT_WIDTH-1:0] port_input_reg;
    logic [gdp_pkg::PORT_WIDTH-1:0] next_direction;
    logic [gdp_pkg::PORT_WIDTH-1:0] next_drive;
    logic next_pullup_dis;
    logic [gdp_pkg::DATA_WIDTH-1:0] next_rdata;
    gdp_pin_if pin ();

    // reset release synchroniser; assertion stays asynchronous
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // merge write data into one register, honouring set and clear aliases
    function automatic logic [gdp_pkg::PORT_WIDTH-1:0] gdp_merge(
        input logic [gdp_pkg::PORT_WIDTH-1:0] cur,
        input logic [gdp_pkg::DATA_WIDTH-1:0] wd,
        input logic wr_full,
        input logic wr_set,
        input logic wr_clr
    );
        logic [gdp_pkg::PORT_WIDTH-1:0] res;
        res = cur;
        if (wr_full) begin
            res = wd;
        end else if (wr_set) begin
            res = cur | wd;
        end else if (wr_clr) begin
            res = cur & ~wd;
        end
        return res;
    endfunction : gdp_merge

    always_comb begin
        next_direction = port_direction_reg;
        next_drive = port_drive_reg;
        next_pullup_dis = global_pullup_disable;
        next_rdata = rdata_o;
        if (clk_en_i) begin
            if (wr_i) begin
                next_direction = gdp_merge(port_direction_reg, wdata_i,
                    addr_i == gdp_pkg::ADDR_DIRECTION, addr_i == gdp_pkg::ADDR_DIR_SET,
                    addr_i == gdp_pkg::ADDR_DIR_CLR);
                next_drive = gdp_merge(port_drive_reg, wdata_i,
                    addr_i == gdp_pkg::ADDR_DRIVE, addr_i == gdp_pkg::ADDR_DRIVE_SET,
                    addr_i == gdp_pkg::ADDR_DRIVE_CLR);
                if (addr_i == gdp_pkg::ADDR_SPECIAL_FUNC) begin
                    next_pullup_dis = wdata_i[gdp_pkg::PULLUP_DIS_BIT];
                end
                // writes to the input register are ignored
            end
            if (rd_i) begin
                case (addr_i)
                    gdp_pkg::ADDR_INPUT: next_rdata = port_input_reg;
                    gdp_pkg::ADDR_DIRECTION: next_rdata = port_direction_reg;
                    gdp_pkg::ADDR_DRIVE: next_rdata = port_drive_reg;
                    gdp_pkg::ADDR_SPECIAL_FUNC: begin
                        next_rdata = gdp_pkg::READ_ZERO;
                        next_rdata[gdp_pkg::PULLUP_DIS_BIT] = global_pullup_disable;
                    end
                    default: next_rdata = gdp_pkg::READ_ZERO;
                endcase
            end else begin
                next_rdata = gdp_pkg::READ_ZERO;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            port_direction_reg <= gdp_pkg::RESET_DIRECTION;
            port_drive_reg <= gdp_pkg::RESET_DRIVE;
            global_pullup_disable <= gdp_pkg::RESET_PULLUP_DIS;
            rdata_o <= gdp_pkg::READ_ZERO;
        end else begin
            port_direction_reg <= next_direction;
            port_drive_reg <= next_drive;
            global_pullup_disable <= next_pullup_dis;
            rdata_o <= next_rdata;
        end
    end

    assign pin.direction = port_direction_reg;
    assign pin.drive = port_drive_reg;
    assign pin.pullup_dis = global_pullup_disable;

    // raw pin reset so pads float the moment reset asserts
    gdp_pad_ctrl u_pad (
        .rst_active_i(~rstn_i),
        .pin(pin.pad)
    );

    // pins are decoded independently, so any subset may be lent out
    assign pad_out_o = pin.out_level;
    assign pad_oe_n_o = pin.out_en_n;
    assign pad_pullup_o = pin.pullup_en;

    // one cycle from drive write to readable level
    gdp_input_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rst_sync),
        .clk_en_i(clk_en_i),
        .pin_i(pad_in_i),
        .sync_o(port_input_reg)
    );
endmodule : gdp_port

/* verification/gdp_port_assertions.sv */
// concurrent checks on the port pins and register bus
`timescale 1ns/10ps
module gdp_port_assertions (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] pad_in_i,
    input wire logic [7:0] pad_out_o,
    input wire logic [7:0] pad_oe_n_o,
    input wire logic [7:0] pad_pullup_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic w;
    assign w = wr_i && clk_en_i;
    sequence s_steady;
        ($stable(pad_in_i) && clk_en_i) [*3];
    endsequence
    AST_DIR: assert property (w && addr_i == gdp_pkg::ADDR_DIRECTION |=> pad_oe_n_o == ~$past(wdata_i))
        else $error("dir");
    AST_DRV: assert property (w && addr_i == gdp_pkg::ADDR_DRIVE |=> pad_out_o == $past(wdata_i))
        else $error("drv");
    AST_PULL: assert property ((pad_pullup_o & ~(pad_oe_n_o & pad_out_o)) == 8'h00)
        else $error("pull");
    AST_PULLUP_OFF: assert property (w && addr_i == gdp_pkg::ADDR_SPECIAL_FUNC && wdata_i[2]
        |=> pad_pullup_o == 8'h00)
        else $error("pullup not disabled");
    AST_RST: assert property (disable iff (1'b0) !rstn_i |-> pad_oe_n_o == 8'hFF && pad_pullup_o == 8'h00)
        else $error("rst");
    AST_SET: assert property (w && addr_i == gdp_pkg::ADDR_DRIVE_SET
        |=> pad_out_o == ($past(pad_out_o) | $past(wdata_i)))
        else $error("set");
    AST_CLR: assert property (w && addr_i == gdp_pkg::ADDR_DIR_CLR
        |=> pad_oe_n_o == ($past(pad_oe_n_o) | $past(wdata_i)))
        else $error("clr");
    AST_SYNC: assert property (s_steady ##0 rd_i && addr_i == gdp_pkg::ADDR_INPUT
        |=> rdata_o == $past(pad_in_i))
        else $error("sync");
    // read data stand for one enabled cycle only, zero after an enabled cycle without a read
    AST_RDZ: assert property (clk_en_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data not cleared");
endmodule : gdp_port_assertions
bind gdp_port gdp_port_assertions u_chk (.*);

/* verification/gdp_pin_model.sv */
// external circuitry model on the port pins
`timescale 1ns/10ps
module gdp_pin_model (
    input wire logic clk_i,
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_n_i,
    input wire logic [7:0] pullup_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] level_o
);
    // a floating pin wanders so a stale value never passes
    logic [7:0] flt = 8'h00;
    always @(posedge clk_i) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n_i[i]) level_o[i] = out_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pullup_i[i]) level_o[i] = 1'b1;
            else level_o[i] = flt[i];
        end
    end
endmodule : gdp_pin_model

/* verification/tb_top.sv */
// self-checking testbench for the general digital io port
`timescale 1ns/10ps
module tb_top;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, clk_en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] rdata_o, pad_out_o, pad_oe_n_o, pad_pullup_o, pad_in_i;
    int errors = 0, cmp_count = 0;
    gdp_port u_dut (.*);
    gdp_pin_model u_pins (.clk_i(sys_clk_i), .out_i(pad_out_o), .oe_n_i(pad_oe_n_o),
        .pullup_i(pad_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad_in_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
    endtask : acc
    task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(n, e, rdata_o);
    endtask : rdc
    task automatic t_reset;
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        chk("oe_n", 8'hFF, pad_oe_n_o);
        chk("pullup", 8'h00, pad_pullup_o);
        rstn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rdc("dir", gdp_pkg::ADDR_DIRECTION, 8'h00);
        rdc("drv", gdp_pkg::ADDR_DRIVE, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_rw;
        ext_en <= 8'hA0;
        ext_val <= 8'h20;
        acc(1'b1, gdp_pkg::ADDR_DRIVE, 8'h5A);
        acc(1'b1, gdp_pkg::ADDR_DIRECTION, 8'h0F);
        acc(1'b1, gdp_pkg::ADDR_INPUT, 8'hFF);
        chk("oe_n", 8'hF0, pad_oe_n_o);
        chk("out", 8'h5A, pad_out_o);
        chk("pullup", 8'h50, pad_pullup_o);
        rdc("dir", gdp_pkg::ADDR_DIRECTION, 8'h0F);
        rdc("unmapped", 4'hF, 8'h00);
        rdc("input", gdp_pkg::ADDR_INPUT, 8'h7A);
        acc(1'b1, gdp_pkg::ADDR_DRIVE, 8'h55);
        rdc("input", gdp_pkg::ADDR_INPUT, 8'h75);
        $display("read write test done");
    endtask : t_rw
    task automatic t_bits;
        acc(1'b1, gdp_pkg::ADDR_DRIVE_SET, 8'h81);
        acc(1'b1, gdp_pkg::ADDR_DIR_CLR, 8'h03);
        acc(1'b1, gdp_pkg::ADDR_DIR_SET, 8'h10);
        acc(1'b1, gdp_pkg::ADDR_DRIVE_CLR, 8'h04);
        rdc("drv", gdp_pkg::ADDR_DRIVE, 8'hD1);
        rdc("dir", gdp_pkg::ADDR_DIRECTION, 8'h1C);
        rdc("alias", gdp_pkg::ADDR_DRIVE_SET, 8'h00);
        chk("pullup", 8'hC1, pad_pullup_o);
        $display("bit test done");
    endtask : t_bits
    task automatic t_pud;
        acc(1'b1, gdp_pkg::ADDR_SPECIAL_FUNC, 8'h04);
        chk("pullup", 8'h00, pad_pullup_o);
        chk("out", 8'hD1, pad_out_o);
        rdc("sfr", gdp_pkg::ADDR_SPECIAL_FUNC, 8'h04);
        acc(1'b1, gdp_pkg::ADDR_SPECIAL_FUNC, 8'h00);
        chk("pullup", 8'hC1, pad_pullup_o);
        @(posedge sys_clk_i);
        clk_en_i <= 1'b0;
        acc(1'b1, gdp_pkg::ADDR_DRIVE, 8'h00);
        chk("frozen", 8'hD1, pad_out_o);
        clk_en_i <= 1'b1;
        $display("pull-up test done");
    endtask : t_pud
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        t_reset();
        t_rw();
        t_bits();
        t_pud();
        t_reset();
        stop_test();
    end
    initial begin
        #20000;
        errors++;
        stop_test();
    end
endmodule : tb_top
